// File: pkg/afh_pkg.sv
// Constants, types and register map of the amplifier fault handler
package afh_pkg;
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned DC_TIME_MS    = 420;
    localparam int unsigned DC_HOLD_CYC   = DC_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned REC_TIME_MS   = 100;
    localparam int unsigned REC_CYC       = REC_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned CNT_W         = 28;
    localparam int unsigned DUTY_WIN      = 250;
    localparam int unsigned DUTY_PCT      = 60;
    localparam int unsigned DUTY_THR      = DUTY_WIN * DUTY_PCT / 100;
    localparam int unsigned WIN_W         = 8;
    localparam int unsigned NCH           = 2;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_STATUS     = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT   = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK   = 8'h0C;

    // Control fields
    localparam int unsigned CTRL_SD_BIT   = 0;
    localparam int unsigned CTRL_PARALLEL_BRIDGE_MODE_BIT = 1;
    localparam int unsigned CTRL_FREQ_BIT = 2;
    localparam int unsigned CTRL_GAIN_LSB = 4;
    localparam logic [5:0]  CTRL_RESET    = 6'h01;
    localparam logic [5:0]  CTRL_MASK     = 6'h37;

    // Status fields above the six error bits
    localparam int unsigned STAT_LATCH_BIT = 8;
    localparam int unsigned STAT_FAULT_BIT = 9;
    localparam int unsigned STAT_HW_BIT    = 10;
    localparam int unsigned STAT_RUN_BIT   = 11;

    // Error bit positions, shared by status, irq status and mask
    localparam int unsigned ERR_OV  = 0;
    localparam int unsigned ERR_UV  = 1;
    localparam int unsigned ERR_CLK = 2;
    localparam int unsigned ERR_OC  = 3;
    localparam int unsigned ERR_DC  = 4;
    localparam int unsigned ERR_OT  = 5;
    localparam int unsigned NERR    = 6;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_LATCH = 2'b01
    } afh_state_t;

    // Raw detections from the protection comparators
    typedef struct packed {
        logic overtemp_hyst;
        logic overtemp_error;
        logic overcurrent_error;
        logic clk_stopped;
        logic clk_rate_bad;
        logic clk_ratio_bad;
        logic undervoltage_error;
        logic overvoltage_error;
    } afh_det_t;

    // Static configuration pins
    typedef struct packed {
        logic       parallel_bridge_mode;
        logic       freq_half;
        logic [1:0] gain;
    } afh_cfg_t;
endpackage : afh_pkg

// File: logic/afh_fault_handler.sv
// Fault classification, recovery and notification for the amplifier
`timescale 1ns/10ps
`default_nettype none
module afh_fault_handler
    import afh_pkg::*;
#(
    parameter int unsigned DC_HOLD  = DC_HOLD_CYC,
    parameter int unsigned REC_HOLD = REC_CYC
) (
    input  wire logic             clk_sys,              // System clock
    input  wire logic             sys_rst,              // Sync reset
    input  wire logic [7:0]       wb_adr_i,             // Byte address
    input  wire logic [31:0]      wb_dat_i,             // Write data
    input  wire logic [3:0]       wb_sel_i,             // Byte enables
    input  wire logic             wb_we_i,              // Write strobe
    input  wire logic             wb_cyc_i,             // Cycle
    input  wire logic             wb_stb_i,             // Strobe
    output logic [31:0]           wb_dat_o,             // Read data
    output logic                  wb_ack_o,             // Acknowledge
    input  wire afh_det_t         det_i,                // Comparator flags
    input  wire logic [NCH-1:0]   pwm_p_i,              // Positive PWM
    input  wire logic [NCH-1:0]   pwm_m_i,              // Negative PWM
    input  wire logic             amp_shutdown_n_i,     // Shutdown pin
    input  wire logic             hw_mode_i,            // Hardware mode pin
    input  wire afh_cfg_t         cfg_pins_i,           // Static pins
    output logic                  amp_fault_n_o,        // Fault pin out
    output logic                  amp_fault_n_oe,       // Fault pin enable
    output logic                  amp_run_o,            // Playback enable
    output afh_cfg_t              cfg_o,                // Active config
    output logic                  irq_o                 // Interrupt
);
    localparam int unsigned SYN_W = $bits(afh_det_t) + 2 * NCH + 2
                                    + $bits(afh_cfg_t);

    // Two-stage synchroniser for every pin input
    logic [SYN_W-1:0] syn1_reg;
    logic [SYN_W-1:0] syn2_reg;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            syn1_reg <= '0;
            syn2_reg <= '0;
        end else begin
            syn1_reg <= {det_i, pwm_p_i, pwm_m_i, amp_shutdown_n_i,
                         hw_mode_i, cfg_pins_i};
            syn2_reg <= syn1_reg;
        end
    end

    afh_det_t         det;
    logic [NCH-1:0]   pwm_p;
    logic [NCH-1:0]   pwm_m;
    logic             sd_pin_n;
    logic             hw_mode;
    afh_cfg_t         cfg_pins;
    assign {det, pwm_p, pwm_m, sd_pin_n, hw_mode, cfg_pins} = syn2_reg;

    // Register state
    logic [5:0]       ctrl_reg;
    logic [NERR-1:0]  irq_stat_reg;
    logic [NERR-1:0]  irq_mask_reg;
    logic [NERR-1:0]  err_d_reg;
    afh_state_t       state_reg;
    logic [CNT_W-1:0] rec_cnt_reg;
    logic             saw_low_reg;
    logic             sd_d_reg;

    // DC detect: per-channel window duty measure and polarity hold timer
    logic [NCH-1:0]   dc_hit;
    logic [WIN_W-1:0] win_cnt_reg;
    logic             win_end;
    assign win_end = (win_cnt_reg == WIN_W'(DUTY_WIN - 1));

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            win_cnt_reg <= '0;
        end else if (win_end) begin
            win_cnt_reg <= '0;
        end else begin
            win_cnt_reg <= win_cnt_reg + WIN_W'(1);
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_dc
            logic [WIN_W-1:0] pos_cnt_reg;
            logic [WIN_W-1:0] neg_cnt_reg;
            logic [1:0]       pol_reg;
            logic [1:0]       pol_now;
            logic [CNT_W-1:0] hold_reg;
            logic             pos_on;
            logic             neg_on;
            assign pos_on  = pwm_p[ch] & ~pwm_m[ch];
            assign neg_on  = pwm_m[ch] & ~pwm_p[ch];
            assign pol_now = {neg_cnt_reg > WIN_W'(DUTY_THR),
                              pos_cnt_reg > WIN_W'(DUTY_THR)};
            assign dc_hit[ch] = (hold_reg > CNT_W'(DC_HOLD));

            always_ff @(posedge clk_sys) begin
                if (sys_rst || win_end) begin
                    pos_cnt_reg <= '0;
                    neg_cnt_reg <= '0;
                end else begin
                    pos_cnt_reg <= pos_cnt_reg + WIN_W'(pos_on);
                    neg_cnt_reg <= neg_cnt_reg + WIN_W'(neg_on);
                end
            end

            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    pol_reg  <= '0;
                    hold_reg <= '0;
                end else if (win_end) begin
                    pol_reg <= pol_now;
                    if (pol_now != 2'h0 && pol_now == pol_reg) begin
                        if (!dc_hit[ch]) begin
                            hold_reg <= hold_reg + CNT_W'(DUTY_WIN);
                        end
                    end else begin
                        hold_reg <= '0;
                    end
                end
            end
        end
    endgenerate

    // Error classification
    logic [NERR-1:0] err;
    logic            clk_err;
    logic            latch_err;
    logic            sd_n;
    logic            sd_rise;
    logic            rec_done;
    logic            latch_clear_ok;
    assign clk_err = det.clk_ratio_bad | det.clk_rate_bad
                     | det.clk_stopped;
    always_comb begin
        err          = '0;
        err[ERR_OV]  = det.overvoltage_error;
        err[ERR_UV]  = det.undervoltage_error;
        err[ERR_CLK] = clk_err;
        err[ERR_OC]  = det.overcurrent_error;
        err[ERR_DC]  = |dc_hit;
        err[ERR_OT]  = det.overtemp_error;
    end
    assign latch_err = err[ERR_OC] | err[ERR_DC] | err[ERR_OT];
    // Software bit only counts outside hardware mode
    assign sd_n = sd_pin_n & (hw_mode | ctrl_reg[CTRL_SD_BIT]);
    assign sd_rise  = sd_n & ~sd_d_reg;
    assign rec_done = (rec_cnt_reg >= CNT_W'(REC_HOLD));
    assign latch_clear_ok = rec_done & saw_low_reg & ~err[ERR_OC]
                            & ~err[ERR_DC] & ~det.overtemp_hyst;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sd_d_reg <= 1'b0;
        end else begin
            sd_d_reg <= sd_n;
        end
    end

    // Latching fault state machine
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg   <= ST_RUN;
            rec_cnt_reg <= '0;
            saw_low_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_RUN: begin
                    rec_cnt_reg <= '0;
                    saw_low_reg <= 1'b0;
                    if (sd_n && latch_err) begin
                        state_reg <= ST_LATCH;
                    end
                end
                ST_LATCH: begin
                    if (!rec_done) begin
                        rec_cnt_reg <= rec_cnt_reg + CNT_W'(1);
                    end
                    if (!sd_n && rec_done) begin
                        saw_low_reg <= 1'b1;
                    end
                    if (sd_rise) begin
                        if (latch_clear_ok) begin
                            state_reg <= ST_RUN;
                        end else begin
                            rec_cnt_reg <= '0;
                            saw_low_reg <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // Fault pin and playback enable
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            amp_fault_n_o  <= 1'b0;
            amp_fault_n_oe <= 1'b0;
            amp_run_o      <= 1'b0;
        end else begin
            amp_fault_n_o  <= 1'b0;
            // Released once recovery elapsed and shutdown went low
            amp_fault_n_oe <= clk_err
                | (state_reg == ST_LATCH && !(rec_done && saw_low_reg))
                | (state_reg == ST_RUN && sd_n && latch_err);
            amp_run_o      <= sd_n & (state_reg == ST_RUN) & ~latch_err
                & ~err[ERR_OV] & ~err[ERR_UV] & ~clk_err;
        end
    end

    // Configuration: pins in hardware mode, register otherwise
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cfg_o <= '0;
        end else if (hw_mode) begin
            cfg_o <= cfg_pins;
        end else begin
            cfg_o.parallel_bridge_mode <= ctrl_reg[CTRL_PARALLEL_BRIDGE_MODE_BIT];
            cfg_o.freq_half            <= ctrl_reg[CTRL_FREQ_BIT];
            cfg_o.gain <= ctrl_reg[CTRL_GAIN_LSB +: 2];
        end
    end

    // Wishbone slave: ack one cycle after strobe
    logic wb_req;
    logic wb_wr;
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr  = wb_req & wb_we_i & wb_sel_i[0];

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= '0;
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    REG_CTRL:     wb_dat_o <= 32'(ctrl_reg);
                    REG_STATUS:   wb_dat_o <= 32'({sd_n & ~latch_err,
                                     hw_mode, amp_fault_n_oe,
                                     state_reg == ST_LATCH, 2'h0, err});
                    REG_IRQ_STAT: wb_dat_o <= 32'(irq_stat_reg);
                    REG_IRQ_MASK: wb_dat_o <= 32'(irq_mask_reg);
                    default:      wb_dat_o <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_reg     <= CTRL_RESET;
            irq_mask_reg <= '0;
        end else if (wb_wr) begin
            if (wb_adr_i == REG_CTRL) begin
                ctrl_reg <= wb_dat_i[5:0] & CTRL_MASK;
            end
            if (wb_adr_i == REG_IRQ_MASK) begin
                irq_mask_reg <= wb_dat_i[NERR-1:0];
            end
        end
    end

    // Sticky event bits, set wins over write-one-to-clear
    logic [NERR-1:0] irq_clr;
    assign irq_clr = (wb_wr && wb_adr_i == REG_IRQ_STAT)
                     ? wb_dat_i[NERR-1:0] : '0;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            err_d_reg    <= '0;
            irq_stat_reg <= '0;
            irq_o        <= 1'b0;
        end else begin
            err_d_reg    <= err;
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | (err & ~err_d_reg);
            irq_o        <= |(((irq_stat_reg & ~irq_clr)
                               | (err & ~err_d_reg)) & irq_mask_reg);
        end
    end
endmodule : afh_fault_handler
`default_nettype wire

// File: test/afh_fault_handler_props.sv
// Port-level checks for the amplifier fault handler
`timescale 1ns/10ps
`default_nettype none
module afh_fault_handler_props
    import afh_pkg::*;
(
    input wire logic           clk_sys,          // System clock
    input wire logic           sys_rst,          // Sync reset
    input wire logic [31:0]    wb_dat_o,         // Read data
    input wire logic           wb_ack_o,         // Acknowledge
    input wire logic           wb_cyc_i,         // Cycle
    input wire logic           wb_stb_i,         // Strobe
    input wire afh_det_t       det_i,            // Detections
    input wire logic [NCH-1:0] pwm_p_i,          // Positive PWM
    input wire logic [NCH-1:0] pwm_m_i,          // Negative PWM
    input wire logic           amp_shutdown_n_i, // Shutdown pin
    input wire logic           hw_mode_i,        // Hardware mode
    input wire afh_cfg_t       cfg_pins_i,       // Static pins
    input wire logic           amp_fault_n_o,    // Fault level
    input wire logic           amp_fault_n_oe,   // Fault enable
    input wire logic           amp_run_o,        // Playback enable
    input wire afh_cfg_t       cfg_o             // Active config
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_drive_low;
        amp_fault_n_o == 1'b0;
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("fault pin level not low");
    property p_clk_fault;
        (!sys_rst && |det_i[4:2]) [*4] |-> amp_fault_n_oe;
    endproperty
    a_clk_fault: assert property (p_clk_fault)
        else $error("clock error without fault pull");
    property p_clk_run;
        (!sys_rst && |det_i[4:2]) [*4] |-> !amp_run_o;
    endproperty
    a_clk_run: assert property (p_clk_run)
        else $error("playing during clock error");
    property p_oc_latch;
        (!sys_rst && det_i.overcurrent_error && amp_shutdown_n_i) [*5]
            |-> amp_fault_n_oe;
    endproperty
    a_oc_latch: assert property (p_oc_latch)
        else $error("over-current without fault pull");
    property p_silent;
        (!sys_rst && det_i[7:2] == 6'h00 && pwm_p_i == pwm_m_i
            && !amp_fault_n_oe) [*4] |=> !amp_fault_n_oe;
    endproperty
    a_silent: assert property (p_silent)
        else $error("fault pulled with no latching cause");
    property p_sd_run;
        (!sys_rst && !amp_shutdown_n_i) [*4] |-> !amp_run_o;
    endproperty
    a_sd_run: assert property (p_sd_run)
        else $error("playing while shut down");
    property p_ack;
        !sys_rst && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus request not acknowledged");
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle)
        else $error("read data outside ack");
    property p_cfg_hw;
        (!sys_rst && hw_mode_i && $stable(cfg_pins_i)) [*4]
            |-> cfg_o == cfg_pins_i;
    endproperty
    a_cfg_hw: assert property (p_cfg_hw)
        else $error("config not taken from pins");
endmodule : afh_fault_handler_props

bind afh_fault_handler afh_fault_handler_props i_afh_fault_handler_props (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .det_i(det_i), .pwm_p_i(pwm_p_i), .pwm_m_i(pwm_m_i),
    .amp_shutdown_n_i(amp_shutdown_n_i), .hw_mode_i(hw_mode_i),
    .cfg_pins_i(cfg_pins_i), .amp_fault_n_o(amp_fault_n_o),
    .amp_fault_n_oe(amp_fault_n_oe), .amp_run_o(amp_run_o), .cfg_o(cfg_o));
`default_nettype wire

// File: test/afh_host_model.sv
// Host model: pulled-up fault wire and shutdown pin driver
`timescale 1ns/10ps
`default_nettype none
module afh_host_model (
    input  wire logic clk_sys,        // System clock
    input  wire logic fault_oe,       // Device pulls fault line
    input  wire logic fault_o,        // Device drive level
    input  wire logic tie_en,         // Fault wired to shutdown
    input  wire logic sd_req_n,       // Manual shutdown level
    output logic      amp_fault_n,    // Fault wire level
    output logic      amp_shutdown_n  // Shutdown pin
);
    assign amp_fault_n = fault_oe ? fault_o : 1'b1;

    always_ff @(posedge clk_sys) begin
        amp_shutdown_n <= tie_en ? amp_fault_n : sd_req_n;
    end
endmodule : afh_host_model
`default_nettype wire

// File: test/test_amp_fault_handler.sv
// Self-checking bench for the amplifier fault handler
`timescale 1ns/10ps
`default_nettype none
module test_amp_fault_handler;
    import afh_pkg::*;
    localparam int unsigned REC = 50;
    localparam int unsigned DCH = 2000;
    logic           clk_sys = 1'b0;
    logic           sys_rst = 1'b1;
    logic [7:0]     adr     = 8'h00;
    logic [31:0]    wdat    = 32'h0;
    logic [31:0]    rdat, q;
    logic           we = 1'b0, cyc = 1'b0, stb = 1'b0, ack;
    afh_det_t       det     = '0;
    logic [NCH-1:0] pwm_p   = '0;
    logic [NCH-1:0] pwm_m   = '0;
    logic [3:0]     sel     = 4'hF;
    logic           hw = 1'b0, sd_req = 1'b1, tie = 1'b0;
    logic           sd_n, f_n, f_oe, run, irq, fw;
    afh_cfg_t       cfg     = '0;
    afh_cfg_t       cfg_o;
    int             fails = 0, n_checks = 0;

    always #20 clk_sys = ~clk_sys;

    afh_fault_handler #(.DC_HOLD(DCH), .REC_HOLD(REC)) i_afh_fault_handler (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .det_i(det),
        .pwm_p_i(pwm_p), .pwm_m_i(pwm_m), .amp_shutdown_n_i(sd_n),
        .hw_mode_i(hw), .cfg_pins_i(cfg), .amp_fault_n_o(f_n),
        .amp_fault_n_oe(f_oe), .amp_run_o(run), .cfg_o(cfg_o), .irq_o(irq));
    afh_host_model i_afh_host_model (.clk_sys(clk_sys), .fault_oe(f_oe),
        .fault_o(f_n), .tie_en(tie), .sd_req_n(sd_req), .amp_fault_n(fw),
        .amp_shutdown_n(sd_n));

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : step
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
        int n;
        n = 0;
        adr  <= a;
        we   <= w;
        wdat <= d;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        @(posedge clk_sys);
        while (ack !== 1'b1 && n < 16) begin
            @(posedge clk_sys);
            n++;
        end
        chk("wb_ack", 32'h1, 32'(ack));
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_sys);
    endtask : wb
    task automatic pulse_sd;
        sd_req <= 1'b0;
        step(6);
        chk("sd_run", 32'h0, 32'(run));
        sd_req <= 1'b1;
        step(8);
    endtask : pulse_sd

    task automatic t_regs;
        wb(REG_CTRL, 1'b0, 32'h0);
        chk("ctrl", {26'h0, CTRL_RESET}, q);
        sel <= 4'hE;
        wb(REG_CTRL, 1'b1, 32'h0);
        sel <= 4'hF;
        wb(REG_CTRL, 1'b0, 32'h0);
        chk("sel_ign", {26'h0, CTRL_RESET}, q);
        wb(8'h10, 1'b0, 32'h0);
        chk("unmapped", 32'h0, q);
    endtask : t_regs
    task automatic t_nonlatch;
        wb(REG_IRQ_MASK, 1'b1, 32'h1);
        det.overvoltage_error <= 1'b1;
        step(6);
        chk("ov_oe", 32'h0, 32'(f_oe));
        chk("ov_irq", 32'h1, 32'(irq));
        det.overvoltage_error  <= 1'b0;
        det.undervoltage_error <= 1'b1;
        step(6);
        chk("uv_oe", 32'h0, 32'(f_oe));
        det.undervoltage_error <= 1'b0;
        step(6);
        chk("nl_run", 32'h1, 32'(run));
        wb(REG_IRQ_STAT, 1'b1, 32'h3);
        chk("irq_clr", 32'h0, 32'(irq));
        wb(REG_IRQ_MASK, 1'b1, 32'h0);
        det.overvoltage_error <= 1'b1;
        step(6);
        chk("irq_mask", 32'h0, 32'(irq));
        wb(REG_IRQ_STAT, 1'b0, 32'h0);
        chk("irq_stat", 32'h1, q);
        det.overvoltage_error <= 1'b0;
    endtask : t_nonlatch
    task automatic t_clk;
        for (int i = ERR_CLK; i < ERR_CLK + 3; i++) begin
            det[i] <= 1'b1;
            step(5);
            chk("clk_oe", 32'h1, 32'(f_oe));
            chk("clk_run", 32'h0, 32'(run));
            det[i] <= 1'b0;
            step(5);
            chk("clk_back", 32'h1, 32'(run));
            chk("clk_rel", 32'h0, 32'(f_oe));
        end
    endtask : t_clk
    task automatic t_latch;
        det.overcurrent_error <= 1'b1;
        step(5);
        chk("oc_oe", 32'h1, 32'(f_oe));
        det.overcurrent_error <= 1'b0;
        pulse_sd();
        chk("early", 32'h1, 32'(f_oe));
        step(REC);
        pulse_sd();
        chk("oc_rel", 32'h0, 32'(f_oe));
        chk("oc_run", 32'h1, 32'(run));
        det.overcurrent_error <= 1'b1;
        step(REC + 5);
        pulse_sd();
        chk("relatch", 32'h1, 32'(f_oe));
        wb(REG_STATUS, 1'b0, 32'h0);
        chk("status", 32'((1 << STAT_FAULT_BIT) | (1 << STAT_LATCH_BIT)
            | (1 << ERR_OC)), q);
        det.overcurrent_error <= 1'b0;
        step(REC);
        wb(REG_CTRL, 1'b1, 32'h0);
        step(4);
        wb(REG_CTRL, 1'b1, 32'h1);
        step(6);
        chk("bit_clr", 32'h1, 32'(run));
    endtask : t_latch
    task automatic t_temp;
        det.overtemp_error <= 1'b1;
        det.overtemp_hyst  <= 1'b1;
        step(5);
        det.overtemp_error <= 1'b0;
        tie <= 1'b1;
        step(3 * REC);
        chk("ot_hyst", 32'h0, 32'(run));
        det.overtemp_hyst <= 1'b0;
        step(3 * REC);
        chk("ot_run", 32'h1, 32'(run));
        chk("ot_rel", 32'h1, 32'(fw));
        tie <= 1'b0;
    endtask : t_temp
    task automatic t_hw;
        wb(REG_CTRL, 1'b1, 32'h37);
        chk("sw_cfg", 32'hF, 32'(cfg_o));
        hw <= 1'b1;
        step(5);
        chk("hw_def", 32'h0, 32'(cfg_o));
        wb(REG_CTRL, 1'b1, 32'h37);
        step(3);
        chk("hw_sw", 32'h0, 32'(cfg_o));
        cfg <= 4'hA;
        step(5);
        chk("hw_pin", 32'hA, 32'(cfg_o));
    endtask : t_hw
    task automatic t_dc;
        // Pass 0: channel 0 positive; pass 1: channel 1 negative
        for (int k = 0; k < 2; k++) begin
            pwm_p <= (k == 0) ? 2'b01 : 2'b00;
            pwm_m <= (k == 0) ? 2'b00 : 2'b10;
            step(DCH - 500);
            chk("dc_early", 32'h0, 32'(f_oe));
            step(1200);
            chk("dc_flag", 32'h1, 32'(f_oe));
            pwm_p <= 2'b00;
            pwm_m <= 2'b00;
            sys_rst <= 1'b1;
            step(3);
            sys_rst <= 1'b0;
        end
    endtask : t_dc

    task automatic end_of_test;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #1000000;
        fails++;
        end_of_test();
    end
    initial begin
        step(3);
        sys_rst <= 1'b0;
        t_regs();
        t_nonlatch();
        t_clk();
        t_latch();
        t_temp();
        t_dc();
        t_hw();
        end_of_test();
    end
endmodule : test_amp_fault_handler
`default_nettype wire
